// >>> rtl/liu_pkg.sv
// Purpose: constants and types of the logical instruction unit
// Assumes: 24-bit words, 15-bit immediates and index registers
// Notes: opcodes and subcodes are the printed octal values written in hex
package liu_pkg;
	localparam int WORD_W = 24;
	localparam int IMM_W  = 15;
	localparam int REG_AW = 4;

	// instruction word fields
	localparam int OPC_HI   = 23;
	localparam int OPC_LO   = 18;
	localparam int AMODE_B  = 17;
	localparam int SUB_HI   = 17;
	localparam int SUB_LO   = 15;
	localparam int IDXSEL_HI = 16;
	localparam int IDXSEL_LO = 15;
	localparam int ADDR_HI  = 14;

	// opcodes
	localparam logic [5:0] OP_XOR_IMM = 6'h0e;
	localparam logic [5:0] OP_AND_IMM = 6'h0f;
	localparam logic [5:0] OP_LD_MASK = 6'h17;
	localparam logic [5:0] OP_SSET    = 6'h1d;
	localparam logic [5:0] OP_SINV    = 6'h1e;
	localparam logic [5:0] OP_LPROD   = 6'h1f;

	// subcodes of the A/Q immediate forms
	localparam logic [2:0] SUB_ACC    = 3'h6;
	localparam logic [2:0] SUB_ACC_SX = 3'h4;
	localparam logic [2:0] SUB_EXT    = 3'h7;
	localparam logic [2:0] SUB_EXT_SX = 3'h5;

	// register offsets on the plain port
	localparam logic [REG_AW-1:0] OFS_ACC  = 4'h0;
	localparam logic [REG_AW-1:0] OFS_EXT  = 4'h1;
	localparam logic [REG_AW-1:0] OFS_IDX1 = 4'h2;
	localparam logic [REG_AW-1:0] OFS_IDX2 = 4'h3;
	localparam logic [REG_AW-1:0] OFS_IDX3 = 4'h4;
	localparam logic [REG_AW-1:0] OFS_CTRL = 4'h5;
	localparam logic [REG_AW-1:0] OFS_STAT = 4'h6;

	// control and status bit positions
	localparam int CTRL_RT_FITTED = 0;
	localparam int CTRL_RT_MODE   = 1;
	localparam int CTRL_MONITOR   = 2;
	localparam int STAT_BUSY      = 0;
	localparam int STAT_NOP       = 1;
	localparam int STAT_RT        = 2;
	localparam int STAT_BAD       = 3;

	// reset values
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [2:0] STAT_RST = 3'h0;

	typedef enum logic [1:0] {
		DST_NONE = 2'b00,
		DST_ACC  = 2'b01,
		DST_EXT  = 2'b10,
		DST_IDX  = 2'b11
	} liu_dst_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_IND  = 2'b01,
		ST_OPND = 2'b10
	} liu_state_t;
endpackage

// >>> rtl/liu_alu.sv
// Purpose: combinational operand shaping and logic function
// Assumes: caller presents the decoded word and register values
// Notes: destination select tells the caller which register to load
`timescale 1ns/1ps
module liu_alu
	import liu_pkg::*;
#(
	parameter int DATA_W = WORD_W,
	parameter int IDX_W  = IMM_W
)(
	input  wire logic [DATA_W-1:0] instr_i,
	input  wire logic [DATA_W-1:0] acc_i,
	input  wire logic [DATA_W-1:0] ext_i,
	input  wire logic [IDX_W-1:0]  idx_i,
	input  wire logic [DATA_W-1:0] mem_i,
	output logic      [DATA_W-1:0] res_o,
	output liu_dst_t               dst_o
);
	logic [5:0]        opc;
	logic [2:0]        sub;
	logic [DATA_W-1:0] imm;
	logic [DATA_W-1:0] tgt;

	// operand shaping: sign fill only for subcodes 4 and 5
	always_comb
	begin
		opc = instr_i[OPC_HI:OPC_LO];
		sub = instr_i[SUB_HI:SUB_LO];
		if (sub == SUB_ACC_SX || sub == SUB_EXT_SX)
			imm = {{(DATA_W-IMM_W){instr_i[ADDR_HI]}}, instr_i[ADDR_HI:0]};
		else
			imm = {{(DATA_W-IMM_W){1'b0}}, instr_i[ADDR_HI:0]};
		if (!sub[2])
			tgt = {{(DATA_W-IDX_W){1'b0}}, idx_i};
		else if (sub[0])
			tgt = ext_i;
		else
			tgt = acc_i;
	end

	// function and destination per opcode
	always_comb
	begin
		res_o = '0;
		dst_o = DST_NONE;
		case (opc)
			OP_XOR_IMM:
			begin
				res_o = tgt ^ imm;
				dst_o = !sub[2] ? DST_IDX : (sub[0] ? DST_EXT : DST_ACC);
			end
			OP_AND_IMM:
			begin
				res_o = tgt & imm;
				dst_o = !sub[2] ? DST_IDX : (sub[0] ? DST_EXT : DST_ACC);
			end
			OP_LD_MASK:
			begin
				res_o = ext_i & mem_i;
				dst_o = DST_ACC;
			end
			OP_SSET:
			begin
				res_o = acc_i | mem_i;
				dst_o = DST_ACC;
			end
			OP_SINV:
			begin
				res_o = acc_i ^ mem_i;
				dst_o = DST_ACC;
			end
			OP_LPROD:
			begin
				res_o = acc_i & mem_i;
				dst_o = DST_ACC;
			end
			default:
			begin
				res_o = '0;
				dst_o = DST_NONE;
			end
		endcase
	end
endmodule

// >>> rtl/liu_top.sv
// Purpose: logical instruction group, registers A, Q, index 1-3
// Assumes: storage answers a request with one rdata valid pulse
// Notes: one instruction at a time; ready_o low while busy
`timescale 1ns/1ps
module liu_top
	import liu_pkg::*;
#(
	parameter int DATA_W = WORD_W,
	parameter int IDX_W  = IMM_W
)(
	input  wire logic              core_clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              instr_valid_i,
	input  wire logic [DATA_W-1:0] instr_i,
	output logic                   ready_o,
	output logic                   done_o,
	output logic                   mem_req_o,
	output logic [IDX_W-1:0]       mem_addr_o,
	input  wire logic              mem_rvalid_i,
	input  wire logic [DATA_W-1:0] mem_rdata_i,
	output logic                   rt_req_o,
	output logic                   rt_restore_o,
	output logic [IMM_W-1:0]       rt_field_o,
	input  wire logic [REG_AW-1:0] reg_addr_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic [DATA_W-1:0]      reg_rdata_o
);
	// the adder wraps at the index width, which must match the address field
	initial
	begin
		if (IDX_W != IMM_W || DATA_W <= IMM_W + 8)
			$error("liu_top: unsupported width parameters");
	end

	liu_state_t        st;
	liu_state_t        next_st;
	logic [DATA_W-1:0] ir;
	logic [DATA_W-1:0] next_ir;
	logic [DATA_W-1:0] acc;
	logic [DATA_W-1:0] next_acc;
	logic [DATA_W-1:0] ext;
	logic [DATA_W-1:0] next_ext;
	logic [IDX_W-1:0]  idx      [4];
	logic [IDX_W-1:0]  next_idx [4];
	logic [2:0]        ctrl;
	logic [2:0]        next_ctrl;
	logic [3:0]        stat;
	logic [3:0]        next_stat;
	logic              next_ready;
	logic              next_done;
	logic              next_mem_req;
	logic [IDX_W-1:0]  next_mem_addr;
	logic              next_rt_req;
	logic              next_rt_restore;
	logic [IMM_W-1:0]  next_rt_field;
	logic [DATA_W-1:0] next_rdata;

	// decode view: live word while idle, held word afterwards
	logic [DATA_W-1:0] cur;
	logic [5:0]        opc;
	logic [1:0]        bsel;
	logic              is_imm;
	logic              is_mem;
	logic              rt_ok;
	logic [IDX_W-1:0]  ea;
	logic [DATA_W-1:0] alu_res;
	liu_dst_t          alu_dst;

	always_comb
	begin
		cur    = (st == ST_IDLE) ? instr_i : ir;
		opc    = cur[OPC_HI:OPC_LO];
		bsel   = cur[IDXSEL_HI:IDXSEL_LO];
		is_imm = (opc == OP_XOR_IMM) || (opc == OP_AND_IMM);
		is_mem = (opc == OP_LD_MASK) || (opc == OP_SSET) || (opc == OP_SINV) || (opc == OP_LPROD);
		ea     = cur[ADDR_HI:0] + idx[bsel];
		rt_ok  = ctrl[CTRL_RT_FITTED] && ctrl[CTRL_RT_MODE] && ctrl[CTRL_MONITOR];
	end

	liu_alu #(
		.DATA_W (DATA_W),
		.IDX_W  (IDX_W)
	) u_alu (
		.instr_i (cur),
		.acc_i   (acc),
		.ext_i   (ext),
		.idx_i   (idx[bsel]),
		.mem_i   (mem_rdata_i),
		.res_o   (alu_res),
		.dst_o   (alu_dst)
	);

	// next values: bus writes first so a finishing instruction overrides them
	always_comb
	begin
		next_st         = st;
		next_ir         = ir;
		next_acc        = acc;
		next_ext        = ext;
		next_idx        = idx;
		next_ctrl       = ctrl;
		next_stat       = stat;
		next_done       = 1'b0;
		next_mem_req    = 1'b0;
		next_mem_addr   = mem_addr_o;
		next_rt_req     = 1'b0;
		next_rt_restore = rt_restore_o;
		next_rt_field   = rt_field_o;
		next_rdata      = '0;

		// register port writes
		if (reg_wr_i)
		begin
			case (reg_addr_i)
				OFS_ACC:  next_acc    = reg_wdata_i;
				OFS_EXT:  next_ext    = reg_wdata_i;
				OFS_IDX1: next_idx[1] = reg_wdata_i[IDX_W-1:0];
				OFS_IDX2: next_idx[2] = reg_wdata_i[IDX_W-1:0];
				OFS_IDX3: next_idx[3] = reg_wdata_i[IDX_W-1:0];
				OFS_CTRL: next_ctrl   = reg_wdata_i[2:0];
				default:  next_ctrl   = next_ctrl;
			endcase
		end

		// register port reads, unmapped offsets return zero
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				OFS_ACC:  next_rdata = acc;
				OFS_EXT:  next_rdata = ext;
				OFS_IDX1: next_rdata = {{(DATA_W-IDX_W){1'b0}}, idx[1]};
				OFS_IDX2: next_rdata = {{(DATA_W-IDX_W){1'b0}}, idx[2]};
				OFS_IDX3: next_rdata = {{(DATA_W-IDX_W){1'b0}}, idx[3]};
				OFS_CTRL: next_rdata = {{(DATA_W-3){1'b0}}, ctrl};
				OFS_STAT: next_rdata = {{(DATA_W-4){1'b0}}, stat};
				default:  next_rdata = '0;
			endcase
		end

		case (st)
			ST_IDLE:
			begin
				if (instr_valid_i)
				begin
					next_ir   = instr_i;
					next_stat = '0;
					if (is_imm)
					begin
						next_done = 1'b1;
						if (cur[SUB_HI] || bsel != 2'b00)
						begin
							case (alu_dst)
								DST_ACC: next_acc       = alu_res;
								DST_EXT: next_ext       = alu_res;
								DST_IDX: next_idx[bsel] = alu_res[IDX_W-1:0];
								default: next_acc       = next_acc;
							endcase
						end
						else if (rt_ok)
						begin
							next_rt_req        = 1'b1;
							next_rt_restore    = (opc == OP_AND_IMM);
							next_rt_field      = cur[ADDR_HI:0];
							next_stat[STAT_RT] = 1'b1;
						end
						else
						begin
							next_stat[STAT_NOP] = 1'b1;
						end
					end
					else if (is_mem)
					begin
						next_mem_req  = 1'b1;
						next_mem_addr = ea;
						next_st       = cur[AMODE_B] ? ST_IND : ST_OPND;
						next_stat[STAT_BUSY] = 1'b1;
					end
					else
					begin
						// opcodes outside this group are flagged and dropped
						next_done           = 1'b1;
						next_stat[STAT_BAD] = 1'b1;
					end
				end
			end
			ST_IND:
			begin
				// single level of indirection: word gives the operand address
				if (mem_rvalid_i)
				begin
					next_mem_req  = 1'b1;
					next_mem_addr = mem_rdata_i[IDX_W-1:0];
					next_st       = ST_OPND;
				end
			end
			ST_OPND:
			begin
				if (mem_rvalid_i)
				begin
					if (alu_dst == DST_ACC)
						next_acc = alu_res;
					next_done            = 1'b1;
					next_stat[STAT_BUSY] = 1'b0;
					next_st              = ST_IDLE;
				end
			end
			default:
			begin
				next_st = ST_IDLE;
			end
		endcase

		// index zero reads as zero in address sums and is never stored
		next_idx[0] = '0;
		next_ready  = (next_st == ST_IDLE);
	end

	// state registers
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			st           <= ST_IDLE;
			ir           <= '0;
			acc          <= '0;
			ext          <= '0;
			idx          <= '{default: '0};
			ctrl         <= CTRL_RST;
			stat         <= {1'b0, STAT_RST};
			ready_o      <= 1'b0;
			done_o       <= 1'b0;
			mem_req_o    <= 1'b0;
			mem_addr_o   <= '0;
			rt_req_o     <= 1'b0;
			rt_restore_o <= 1'b0;
			rt_field_o   <= '0;
			reg_rdata_o  <= '0;
		end
		else
		begin
			st           <= next_st;
			ir           <= next_ir;
			acc          <= next_acc;
			ext          <= next_ext;
			idx          <= next_idx;
			ctrl         <= next_ctrl;
			stat         <= next_stat;
			ready_o      <= next_ready;
			done_o       <= next_done;
			mem_req_o    <= next_mem_req;
			mem_addr_o   <= next_mem_addr;
			rt_req_o     <= next_rt_req;
			rt_restore_o <= next_rt_restore;
			rt_field_o   <= next_rt_field;
			reg_rdata_o  <= next_rdata;
		end
	end
endmodule

// >>> tb/liu_top_props.sv
// Purpose: port checks of the logical instruction unit
// Assumes: storage answers a request within 16 cycles
// Notes: bound to liu_top at the foot of this file
`timescale 1ns/1ps
module liu_top_props
	import liu_pkg::*;
#(
	parameter int DATA_W = WORD_W,
	parameter int IDX_W  = IMM_W
)(
	input wire logic              core_clk_i,
	input wire logic              rst_b_i,
	input wire logic              instr_valid_i,
	input wire logic [DATA_W-1:0] instr_i,
	input wire logic              ready_o,
	input wire logic              done_o,
	input wire logic              mem_req_o,
	input wire logic [IDX_W-1:0]  mem_addr_o,
	input wire logic              mem_rvalid_i,
	input wire logic              rt_req_o,
	input wire logic              rt_restore_o,
	input wire logic [IMM_W-1:0]  rt_field_o,
	input wire logic              reg_rd_i,
	input wire logic [DATA_W-1:0] reg_rdata_o
);
	logic [5:0] opc;
	logic       take;
	logic       imm_take;
	logic       mem_take;

	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	// decode of the offered word, only meaningful while idle
	assign opc      = instr_i[OPC_HI:OPC_LO];
	assign take     = instr_valid_i && ready_o;
	assign imm_take = take && (opc == OP_XOR_IMM || opc == OP_AND_IMM);
	assign mem_take = take && (opc == OP_LD_MASK || opc == OP_SSET || opc == OP_SINV || opc == OP_LPROD);

	// operand fetch steps
	sequence s_direct_take;
		mem_take && !instr_i[AMODE_B];
	endsequence
	sequence s_operand_back;
		mem_req_o ##[0:16] mem_rvalid_i;
	endsequence

	a_imm_done: assert property (imm_take |=> done_o && ready_o && !mem_req_o)
		else $error("immediate form not finished next cycle");
	a_mem_request: assert property (mem_take |=> mem_req_o && !ready_o && !done_o)
		else $error("memory form did not request storage");
	a_direct_addr: assert property (s_direct_take and instr_i[16:15] == 2'b00 |=> mem_addr_o == $past(instr_i[IDX_W-1:0]))
		else $error("unindexed address wrong");
	a_done_on_data: assert property (s_direct_take ##1 s_operand_back |=> done_o && ready_o)
		else $error("no completion after operand");
	a_req_busy: assert property (mem_req_o |-> !ready_o)
		else $error("ready while storage requested");
	a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == '0)
		else $error("read data outside read slot");
	a_rt_cause: assert property (rt_req_o |-> $past(take) && $past(instr_i[23:19]) == 5'h07 && $past(instr_i[17:15]) == 3'h0)
		else $error("rt pulse without designator zero");
	a_rt_kind: assert property (rt_req_o |-> rt_restore_o == $past(instr_i[18]) && rt_field_o == $past(instr_i[14:0]))
		else $error("rt kind or field wrong");
endmodule

bind liu_top liu_top_props #(.DATA_W(DATA_W), .IDX_W(IDX_W)) i_props (.core_clk_i, .rst_b_i, .instr_valid_i,
	.instr_i, .ready_o, .done_o, .mem_req_o, .mem_addr_o, .mem_rvalid_i, .rt_req_o, .rt_restore_o, .rt_field_o,
	.reg_rd_i, .reg_rdata_o);

// >>> tb/liu_store_model.sv
// Purpose: main storage answering operand reads
// Assumes: one request outstanding at a time
// Notes: data lines toggle when no answer is given
`timescale 1ns/1ps
module liu_store_model
	import liu_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              req_i,
	input  wire logic [IMM_W-1:0]  addr_i,
	input  wire logic [2:0]        lat_i,
	output logic                   rvalid_o,
	output logic [WORD_W-1:0]      rdata_o,
	output logic [IMM_W-1:0]       addr_o
);
	logic [WORD_W-1:0] mem [0:32767];
	logic [2:0]        cnt;
	logic              busy;

	// slow answers: lat_i extra cycles; stale data never left standing
	always_ff @(posedge clk_i)
	begin
		rvalid_o <= 1'b0;
		rdata_o  <= ~rdata_o;
		if (!rst_b_i)
		begin
			busy    <= 1'b0;
			rdata_o <= '0;
		end
		else if (req_i)
		begin
			busy   <= 1'b1;
			addr_o <= addr_i;
			cnt    <= lat_i;
		end
		else if (busy && cnt == 3'h0)
		begin
			busy     <= 1'b0;
			rvalid_o <= 1'b1;
			rdata_o  <= mem[addr_o];
		end
		else if (busy)
			cnt <= cnt - 3'h1;
	end
endmodule

// >>> tb/tb_logical_instruction_unit.sv
// Purpose: self-checking bench of the logical instruction unit
// Assumes: results are read back over the register port
// Notes: storage latency is stepped across memory forms
`timescale 1ns/1ps
module tb_logical_instruction_unit
	import liu_pkg::*;
;
	logic              core_clk_i = 1'b0;
	logic              rst_b_i = 1'b0;
	logic              instr_valid_i = 1'b0;
	logic [WORD_W-1:0] instr_i = '0;
	logic [REG_AW-1:0] reg_addr_i = '0;
	logic [WORD_W-1:0] reg_wdata_i = '0;
	logic              reg_wr_i = 1'b0;
	logic              reg_rd_i = 1'b0;
	logic [2:0]        mem_lat = 3'h0;
	logic              ready_o, done_o, mem_req_o, mem_rvalid_i, rt_req_o, rt_restore_o, rt_seen;
	logic [IMM_W-1:0]  mem_addr_o, rt_field_o, last_addr;
	logic [WORD_W-1:0] mem_rdata_i, reg_rdata_o, rd_val;
	int                error_cnt = 0;
	int                total_checks = 0;

	always #4 core_clk_i = ~core_clk_i;

	liu_top i_dut (.core_clk_i, .rst_b_i, .instr_valid_i, .instr_i, .ready_o, .done_o, .mem_req_o, .mem_addr_o,
		.mem_rvalid_i, .mem_rdata_i, .rt_req_o, .rt_restore_o, .rt_field_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o);
	liu_store_model i_store (.clk_i(core_clk_i), .rst_b_i, .req_i(mem_req_o), .addr_i(mem_addr_o), .lat_i(mem_lat),
		.rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i), .addr_o(last_addr));

	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_verdict;
		$display("mismatches %0d, checks %0d", error_cnt, total_checks);
		if (error_cnt == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one-cycle strobes on the register port
	task automatic reg_wr(input logic [3:0] a, input logic [23:0] d);
		@(posedge core_clk_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a);
		@(posedge core_clk_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 rd_val = reg_rdata_o;
	endtask

	// offer one instruction, wait bounded for done, keep the rt request of that cycle
	task automatic exec(input logic [23:0] w);
		int n;
		@(posedge core_clk_i);
		instr_valid_i <= 1'b1;
		instr_i       <= w;
		@(posedge core_clk_i);
		instr_valid_i <= 1'b0;
		n = 0;
		#1;
		while (done_o !== 1'b1 && n < 40)
		begin
			@(posedge core_clk_i);
			#1 n++;
		end
		chk("done seen", 24'h1, {23'h0, done_o});
		rt_seen = rt_req_o;
	endtask

	task automatic t_regs;
		for (int a = 0; a < 7; a++)
		begin
			reg_rd(a[3:0]);
			chk("reset value", 24'h0, rd_val);
		end
		reg_wr(4'h9, 24'hffffff);
		reg_rd(4'h9);
		chk("unmapped read", 24'h0, rd_val);
		reg_wr(OFS_IDX1, 24'hffffff);
		reg_rd(OFS_IDX1);
		chk("index width", 24'h007fff, rd_val);
	endtask

	task automatic t_imm_forms;
		logic [2:0]  subs [4] = '{SUB_ACC, SUB_ACC_SX, SUB_EXT, SUB_EXT_SX};
		logic [23:0] opnd;
		logic [3:0]  ofs;
		for (int i = 0; i < 8; i++)
		begin
			ofs  = i[1] ? OFS_EXT : OFS_ACC;
			opnd = i[0] ? {9'h1ff, 15'h4f0a} : {9'h000, 15'h4f0a};
			reg_wr(ofs, 24'ha5c3e1);
			exec({i[2] ? OP_AND_IMM : OP_XOR_IMM, subs[i[1:0]], 15'h4f0a});
			reg_rd(ofs);
			chk("imm result", i[2] ? 24'ha5c3e1 & opnd : 24'ha5c3e1 ^ opnd, rd_val);
		end
	endtask

	task automatic t_index;
		reg_wr(OFS_IDX2, 24'h001234);
		exec({OP_XOR_IMM, 3'h2, 15'h7f0f});
		reg_rd(OFS_IDX2);
		chk("index xor", 24'h006d3b, rd_val);
		reg_wr(OFS_IDX3, 24'h005a5a);
		exec({OP_AND_IMM, 3'h3, 15'h0ff0});
		reg_rd(OFS_IDX3);
		chk("index and", 24'h000a50, rd_val);
		reg_wr(OFS_ACC, 24'h123456);
		reg_wr(OFS_CTRL, 24'h000006);
		exec({OP_XOR_IMM, 3'h0, 15'h7fff});
		chk("rt pulse", 24'h0, {23'h0, rt_seen});
		exec({OP_AND_IMM, 3'h0, 15'h0000});
		reg_rd(OFS_STAT);
		chk("noop stat", 24'h000002, rd_val);
		reg_rd(OFS_ACC);
		chk("noop acc", 24'h123456, rd_val);
		reg_rd(OFS_IDX2);
		chk("noop index", 24'h006d3b, rd_val);
	endtask

	task automatic t_rt;
		reg_wr(OFS_CTRL, 24'h000007);
		exec({OP_XOR_IMM, 3'h0, 15'h0005});
		chk("rt group", {8'h0, 1'b1, 1'b0, 15'h0005}, {8'h0, rt_seen, rt_restore_o, rt_field_o});
		exec({OP_AND_IMM, 3'h0, 15'h0001});
		chk("rt restore", {8'h0, 1'b1, 1'b1, 15'h0001}, {8'h0, rt_seen, rt_restore_o, rt_field_o});
		reg_wr(OFS_CTRL, 24'h000000);
	endtask

	task automatic t_mem;
		logic [5:0]  ops [4] = '{OP_LD_MASK, OP_SSET, OP_SINV, OP_LPROD};
		logic [23:0] ex [4] = '{24'h0ff0f0 & 24'hf9caa2, 24'h4e5dc8 | 24'hf9caa2, 24'h4e5dc8 ^ 24'hf9caa2,
			24'h4e5dc8 & 24'hf9caa2};
		reg_wr(OFS_IDX1, 24'h000010);
		reg_wr(OFS_EXT, 24'h0ff0f0);
		i_store.mem[15'h0008] = 24'hf9caa2;
		for (int i = 0; i < 4; i++)
		begin
			mem_lat <= i[2:0];
			reg_wr(OFS_ACC, 24'h4e5dc8);
			exec({ops[i], 1'b0, i[0] ? 2'b01 : 2'b00, i[0] ? 15'h7ff8 : 15'h0008});
			chk("eff addr", 24'h000008, {9'h0, last_addr});
			reg_rd(OFS_ACC);
			chk("mem result", ex[i], rd_val);
		end
		i_store.mem[15'h0123] = 24'h00ff00;
		i_store.mem[15'h0008] = 24'hff0123;
		reg_wr(OFS_ACC, 24'h4e5dc8);
		exec({OP_SSET, 3'h5, 15'h7ff8});
		chk("indirect addr", 24'h000123, {9'h0, last_addr});
		reg_rd(OFS_ACC);
		chk("indirect set", 24'h4effc8, rd_val);
	endtask

	// hang guard, far beyond the some 175 cycles of the run
	initial
	begin
		#40000;
		error_cnt++;
		$display("CHECK FAILED watchdog expected finish seen hang");
		give_verdict();
	end

	initial
	begin
		repeat (3) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		#1 chk("ready", 24'h1, {23'h0, ready_o});
		t_regs();
		t_imm_forms();
		t_index();
		t_rt();
		t_mem();
		give_verdict();
	end
endmodule
